// *** fubl_pkg.sv ***
// constants, codes and types shared by the boot loader command handler
package fubl_pkg;
  // bus commands and control codes
  localparam logic [7:0] CMD_STATUS = 8'he5;
  localparam logic [7:0] CMD_BOOT = 8'he6;
  localparam logic [7:0] CMD_XFER = 8'he7;
  localparam logic [7:0] BL_ENTER = 8'h01;
  localparam logic [7:0] BL_ERASE = 8'h02;
  localparam logic [7:0] BL_DONE = 8'h03;
  localparam logic [7:0] BL_EXIT = 8'h04;
  localparam logic [7:0] XFER_COUNT = 8'h03;
  // status byte masks
  localparam logic [7:0] ST_ERASED = 8'h01;
  localparam logic [7:0] ST_CRC_BAD = 8'h02;
  localparam logic [7:0] ST_SEQ_ERR = 8'h04;
  localparam logic [7:0] ST_ADDR_ERR = 8'h08;
  localparam logic [7:0] ST_DOWN = 8'h40;
  localparam logic [7:0] ST_BOOT = 8'h80;
  localparam logic [7:0] ST_NONE = 8'h00;
  // byte positions within a write (address byte is position 0)
  localparam logic [7:0] IDX_CMD = 8'h01;
  localparam logic [7:0] IDX_TGT = 8'h02;
  localparam logic [7:0] IDX_DATA = 8'h03;
  localparam logic [7:0] IDX_PAY = 8'h04;
  localparam logic [7:0] IDX_BLEN = 8'h05;
  localparam logic [7:0] IDX_XMIN = 8'h05;
  localparam logic [7:0] IDX_MAX = 8'hff;
  // application space
  localparam int APP_AW = 16;
  localparam logic [APP_AW:0] IMG_MIN = 17'h00002;
  localparam logic [15:0] SEQ_ONE = 16'h0001;
  // readback buffer
  localparam int TX_LEN = 4;
  localparam logic [1:0] TX_LAST = 2'h3;
  // event recorder
  localparam logic [2:0] REC_NUM = 3'h5;
  localparam logic [2:0] REC_LAST = 3'h4;
  // crc engines
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  // apb map
  localparam int APB_AW = 8;
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RSEL = 8'h08;
  localparam logic [7:0] A_RTIME = 8'h0c;
  localparam logic [7:0] A_RDATA = 8'h10;
  localparam logic [7:0] A_RCNT = 8'h14;
  localparam logic [31:0] CFG_RST = 32'h0000_0070;
  localparam int CFG_OTHERS_B = 8;
  localparam int CFG_DOWN_B = 9;
  // timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint REC_TICK_MS = 1;
  localparam int unsigned REC_TICK_CYC = int'(CLK_HZ / 1000 * REC_TICK_MS);
  typedef enum logic [4:0] {
    P_IDLE = 5'b00001,
    P_CMD = 5'b00010,
    P_BOOT = 5'b00100,
    P_XFER = 5'b01000,
    P_SKIP = 5'b10000
  } fubl_parse_t;
endpackage

// *** fubl_crc_if.sv ***
// carrier between the command handler and a crc engine
interface fubl_crc_if #(parameter int W = 8);
  logic clr;
  logic load;
  logic [W-1:0] load_val;
  logic en;
  logic [7:0] data;
  logic [W-1:0] crc;
  modport host(output clr, output load, output load_val, output en, output data, input crc);
  modport eng(input clr, input load, input load_val, input en, input data, output crc);
endinterface

// *** fubl_crc.sv ***
// msb-first byte-wide crc engine, init zero
module fubl_crc #(
  parameter int W = 8,
  parameter logic [W-1:0] POLY = '0
) (
  input wire logic clk,
  input wire logic rstn,
  fubl_crc_if.eng c
);
  import fubl_pkg::*;

  function automatic logic [W-1:0] crc_byte(logic [W-1:0] cur, logic [7:0] d);
    logic [W-1:0] r;
    r = cur;
    for (int i = 7; i >= 0; i--) begin
      if (r[W-1] ^ d[i]) begin
        r = (r << 1) ^ POLY;
      end else begin
        r = r << 1;
      end
    end
    return r;
  endfunction

  logic [W-1:0] crc_r;
  assign c.crc = crc_r;

  // clear beats restore beats update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_r <= '0;
    end else if (c.clr) begin
      crc_r <= '0;
    end else if (c.load) begin
      crc_r <= c.load_val;
    end else if (c.en) begin
      crc_r <= crc_byte(crc_r, c.data);
    end
  end
endmodule // fubl_crc

// *** fubl_core.sv ***
// boot loader command handler with event recorder and apb registers
// How it works
// - boot control write: command, target byte, data byte, pec byte
// - data 1 enter with soft reboot, 2 erase, 3 done, 4 exit with watchdog reboot
// - target byte is ignored for enter and exit
// - output is forced off while in the boot block
// - after erase completes, status reads boot plus erased
// - data transfer uploads packets, first sequence number is zero
// - each accepted packet advances the stored sequence number by one
// - transfer readback: count three, sequence low, sequence high, status
// - appended status uses the same encoding as the status query
// - done checks crc-16 over the image against its last two bytes
// - passing check clears the erased bit; boot stays set, as does a crc flag left by an earlier failed check
// - exit starts the application only if all applications are valid
// - after exit the status reads zero
// - any programming error blocks the application start
// - recorder trigger stores a time-stamped snapshot record
// - five records at most, the newest overwrites the oldest
// - status bits: erased, crc, sequence, address, downstream, boot
module fubl_core #(
  parameter int unsigned TICK_CYC = fubl_pkg::REC_TICK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fubl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_stop,
  input wire logic tx_pop,
  output logic [7:0] tx_byte,
  output logic out_disable,
  output logic sw_reboot,
  output logic wdog_reboot,
  output logic erase_req,
  input wire logic erase_done,
  output logic prog_we,
  output logic [fubl_pkg::APP_AW-1:0] prog_addr,
  output logic [7:0] prog_data,
  input wire logic bb_trigger,
  input wire logic [23:0] snap_in
);
  import fubl_pkg::*;

  function automatic logic [7:0] status_of(logic boot, logic ers, logic crcb, logic seqe, logic adre, logic down);
    status_of = (boot ? ST_BOOT : ST_NONE) | (ers ? ST_ERASED : ST_NONE) | (crcb ? ST_CRC_BAD : ST_NONE)
      | (seqe ? ST_SEQ_ERR : ST_NONE) | (adre ? ST_ADDR_ERR : ST_NONE) | (down ? ST_DOWN : ST_NONE);
  endfunction

  fubl_parse_t st_r;
  logic [7:0] idx_r, tgt_r, dat_r, pend_r;
  logic pend_v_r, pkt_seq_bad_r, pkt_addr_bad_r;
  logic [APP_AW:0] addr_r, addr_cm_r;
  logic [15:0] seq_r, crc_cm_r;
  logic in_boot_r, erased_r, erase_pend_r, app_valid_r, crc_bad_r, seq_err_r, addr_err_r;
  logic [31:0] cfg_r;
  logic [7:0] txb_r [TX_LEN];
  logic [1:0] tx_idx_r;
  logic [31:0] tick_r, ms_r;
  logic [31:0] rec_time [REC_NUM];
  logic [31:0] rec_data [REC_NUM];
  logic [2:0] rec_wp_r, rec_cnt_r, rec_sel_r;
  logic [31:0] rdata_w;
  logic hit_w;

  fubl_crc_if #(.W(8)) pec_c();
  fubl_crc_if #(.W(16)) app_c();
  fubl_crc #(.W(8), .POLY(CRC8_POLY)) u_pec (.clk(clk), .rstn(rstn), .c(pec_c.eng));
  fubl_crc #(.W(16), .POLY(CRC16_POLY)) u_app (.clk(clk), .rstn(rstn), .c(app_c.eng));

  wire logic [7:0] status_w = status_of(in_boot_r, erased_r, crc_bad_r, seq_err_r, addr_err_r, cfg_r[CFG_DOWN_B]);
  wire logic any_err = crc_bad_r | seq_err_r | addr_err_r;
  // a message with its own pec appended leaves a zero remainder
  wire logic pec_ok = (pec_c.crc == '0);
  wire logic boot_go = rx_stop && st_r == P_BOOT && idx_r == IDX_BLEN && pec_ok;
  wire logic tgt_hit = (tgt_r == cfg_r[7:0]);
  // enter and exit never look at the target byte
  wire logic enter_go = boot_go && dat_r == BL_ENTER;
  wire logic exit_go = boot_go && dat_r == BL_EXIT && in_boot_r && app_valid_r && cfg_r[CFG_OTHERS_B] && !any_err;
  wire logic erase_go = boot_go && dat_r == BL_ERASE && tgt_hit && in_boot_r;
  wire logic done_go = boot_go && dat_r == BL_DONE && tgt_hit && in_boot_r;
  wire logic xfer_end = rx_stop && st_r == P_XFER && idx_r >= IDX_XMIN;
  wire logic xfer_ok = xfer_end && pec_ok && !pkt_seq_bad_r && !pkt_addr_bad_r;
  wire logic pkt_go = !pkt_seq_bad_r && !pkt_addr_bad_r;
  // the byte before stop is pec, so payload is written one byte late
  wire logic pay_w = rx_valid && st_r == P_XFER && idx_r >= IDX_PAY && pend_v_r && pkt_go;
  wire logic app_wr = pay_w && !addr_r[APP_AW];

  assign pec_c.clr = rx_start;
  assign pec_c.load = 1'b0;
  assign pec_c.load_val = '0;
  assign pec_c.en = rx_valid;
  assign pec_c.data = rx_byte;
  // image crc builds as bytes land; the stored crc tail zeroes it
  assign app_c.clr = erase_go;
  assign app_c.load = xfer_end && !xfer_ok;
  assign app_c.load_val = crc_cm_r;
  assign app_c.en = app_wr;
  assign app_c.data = pend_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= P_IDLE;
      idx_r <= '0;
      tgt_r <= '0;
      dat_r <= '0;
    end else if (rx_start) begin
      idx_r <= '0;
      st_r <= (st_r == P_IDLE) ? P_CMD : P_SKIP;
    end else if (rx_stop) begin
      st_r <= P_IDLE;
    end else if (rx_valid) begin
      if (idx_r != IDX_MAX) begin
        idx_r <= idx_r + 8'h01;
      end
      if (st_r == P_CMD && idx_r == IDX_CMD) begin
        st_r <= (rx_byte == CMD_BOOT) ? P_BOOT : (rx_byte == CMD_XFER) ? P_XFER : P_SKIP;
      end
      if (idx_r == IDX_TGT) begin
        tgt_r <= rx_byte;
      end
      if (idx_r == IDX_DATA) begin
        dat_r <= rx_byte;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= '0;
      pend_v_r <= 1'b0;
      pkt_seq_bad_r <= 1'b0;
      pkt_addr_bad_r <= 1'b0;
      addr_r <= '0;
      prog_we <= 1'b0;
      prog_addr <= '0;
      prog_data <= '0;
    end else begin
      prog_we <= 1'b0;
      if (rx_start) begin
        pend_v_r <= 1'b0;
        pkt_seq_bad_r <= 1'b0;
        pkt_addr_bad_r <= 1'b0;
      end else if (rx_valid && st_r == P_XFER) begin
        if (idx_r == IDX_DATA && ({rx_byte, tgt_r} != seq_r || !in_boot_r)) begin
          pkt_seq_bad_r <= 1'b1;
        end
        if (idx_r >= IDX_PAY) begin
          pend_r <= rx_byte;
          pend_v_r <= 1'b1;
        end
        if (pay_w && addr_r[APP_AW]) begin
          pkt_addr_bad_r <= 1'b1;
        end
        if (app_wr) begin
          prog_we <= 1'b1;
          prog_addr <= addr_r[APP_AW-1:0];
          prog_data <= pend_r;
          addr_r <= addr_r + 17'h00001;
        end
      end else if (erase_go) begin
        addr_r <= '0;
      // a refused packet rewinds; its bytes are rewritten on retry
      end else if (xfer_end && !xfer_ok) begin
        addr_r <= addr_cm_r;
      end
    end
  end

  // boot state, sequence and status flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_boot_r <= 1'b0;
      out_disable <= 1'b0;
      sw_reboot <= 1'b0;
      wdog_reboot <= 1'b0;
      erase_req <= 1'b0;
      erase_pend_r <= 1'b0;
      erased_r <= 1'b0;
      app_valid_r <= 1'b1;
      crc_bad_r <= 1'b0;
      seq_err_r <= 1'b0;
      addr_err_r <= 1'b0;
      seq_r <= '0;
      addr_cm_r <= '0;
      crc_cm_r <= '0;
    end else begin
      sw_reboot <= 1'b0;
      wdog_reboot <= 1'b0;
      erase_req <= 1'b0;
      if (enter_go) begin
        in_boot_r <= 1'b1;
        out_disable <= 1'b1;
        sw_reboot <= 1'b1;
      end
      if (exit_go) begin
        in_boot_r <= 1'b0;
        out_disable <= 1'b0;
        wdog_reboot <= 1'b1;
      end
      // erase restarts the sequence at zero
      if (erase_go) begin
        erase_req <= 1'b1;
        erase_pend_r <= 1'b1;
        erased_r <= 1'b0;
        app_valid_r <= 1'b0;
        crc_bad_r <= 1'b0;
        seq_err_r <= 1'b0;
        addr_err_r <= 1'b0;
        seq_r <= '0;
        addr_cm_r <= '0;
        crc_cm_r <= '0;
      end else if (erase_done && erase_pend_r) begin
        // erased flag once the flash reports completion
        erased_r <= 1'b1;
        erase_pend_r <= 1'b0;
      end
      if (xfer_end && pec_ok && pkt_seq_bad_r && in_boot_r) begin
        seq_err_r <= 1'b1;
      end
      if (xfer_end && pec_ok && pkt_addr_bad_r) begin
        addr_err_r <= 1'b1;
      end
      if (xfer_ok) begin
        seq_r <= seq_r + SEQ_ONE;
        addr_cm_r <= addr_r;
        crc_cm_r <= app_c.crc;
      end
      // done: zero remainder means the image matches
      if (done_go) begin
        if (crc_cm_r == '0 && addr_cm_r >= IMG_MIN && !seq_err_r && !addr_err_r && !erase_pend_r) begin
          app_valid_r <= 1'b1;
          erased_r <= 1'b0;
        end else begin
          // a failed image is never marked valid
          crc_bad_r <= 1'b1;
        end
      end
    end
  end

  // readback bytes latched when the command byte arrives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < TX_LEN; i++) begin
        txb_r[i] <= '0;
      end
      tx_idx_r <= '0;
      tx_byte <= '0;
    end else begin
      if (rx_valid && st_r == P_CMD && idx_r == IDX_CMD) begin
        if (rx_byte == CMD_XFER) begin
          txb_r[0] <= XFER_COUNT;
          txb_r[1] <= seq_r[7:0];
          txb_r[2] <= seq_r[15:8];
          // same status byte as the status query
          txb_r[3] <= status_w;
        end else if (rx_byte == CMD_STATUS) begin
          txb_r[0] <= status_w;
        end
      end
      if (rx_start) begin
        tx_idx_r <= '0;
      end else if (tx_pop && tx_idx_r != TX_LAST) begin
        tx_idx_r <= tx_idx_r + 2'h1;
      end
      tx_byte <= txb_r[tx_idx_r];
    end
  end

  // millisecond time base for record stamps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_r <= '0;
      ms_r <= '0;
    end else if (tick_r == TICK_CYC - 1) begin
      tick_r <= '0;
      ms_r <= ms_r + 32'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  // snapshot store; array stands in for the nonvolatile pages
  always_ff @(posedge clk) begin
    if (bb_trigger) begin
      rec_time[rec_wp_r] <= ms_r;
      rec_data[rec_wp_r] <= {status_w, snap_in};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rec_wp_r <= '0;
      rec_cnt_r <= '0;
    end else if (bb_trigger) begin
      rec_wp_r <= (rec_wp_r == REC_LAST) ? 3'h0 : rec_wp_r + 3'h1;
      if (rec_cnt_r != REC_NUM) begin
        rec_cnt_r <= rec_cnt_r + 3'h1;
      end
    end
  end

  always_comb begin
    rdata_w = '0;
    hit_w = 1'b1;
    unique case (paddr)
      A_CFG: rdata_w = cfg_r;
      A_STAT: rdata_w = {7'h00, app_valid_r, seq_r, status_w};
      A_RSEL: rdata_w = {29'h0, rec_sel_r};
      A_RTIME: rdata_w = (rec_sel_r < rec_cnt_r) ? rec_time[rec_sel_r] : 32'h0;
      A_RDATA: rdata_w = (rec_sel_r < rec_cnt_r) ? rec_data[rec_sel_r] : 32'h0;
      A_RCNT: rdata_w = {29'h0, rec_cnt_r};
      default: hit_w = 1'b0;
    endcase
  end

  // apb slave with one wait state; write lands on the ready edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      cfg_r <= CFG_RST;
      rec_sel_r <= '0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0 : rdata_w;
        pslverr <= !hit_w;
      end
      if (psel && penable && pready && pwrite) begin
        if (paddr == A_CFG) begin
          cfg_r <= {22'h0, pwdata[9:0]};
        end
        if (paddr == A_RSEL && pwdata[2:0] < REC_NUM) begin
          rec_sel_r <= pwdata[2:0];
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_seq_advance: assert property (xfer_ok |=> seq_r == $past(seq_r) + SEQ_ONE)
    else $error("sequence did not advance on accepted packet");
  chk_pec_hold: assert property ((xfer_end && !pec_ok) |=> $stable(seq_r) && addr_r == $past(addr_cm_r))
    else $error("bad pec packet changed sequence or address");
  chk_enter_reboot: assert property (enter_go |=> sw_reboot && in_boot_r && out_disable ##1 !sw_reboot)
    else $error("enter did not reboot into boot block");
  chk_boot_out_off: assert property (in_boot_r |-> out_disable)
    else $error("output left on in boot block");
  chk_erase_status: assert property (
    (erase_done && erase_pend_r && !erase_go) |=> (status_w & ~ST_DOWN) == (ST_BOOT | ST_ERASED))
    else $error("status after erase wrong");
  chk_xfer_readback: assert property (
    (rx_valid && st_r == P_CMD && idx_r == IDX_CMD && rx_byte == CMD_XFER)
    |=> txb_r[0] == XFER_COUNT && {txb_r[2], txb_r[1]} == $past(seq_r) && txb_r[3] == $past(status_w))
    else $error("transfer readback bytes wrong");
  chk_done_pass: assert property (
    (done_go && crc_cm_r == '0 && addr_cm_r >= IMG_MIN && !any_err && !erase_pend_r)
    |=> (status_w & ~ST_DOWN) == ST_BOOT && app_valid_r)
    else $error("passing check did not leave boot-only status");
  chk_exit_gate: assert property (
    $rose(wdog_reboot) |-> $past(app_valid_r && cfg_r[CFG_OTHERS_B] && !any_err) && !in_boot_r)
    else $error("exit taken with invalid application");
  chk_exit_status: assert property (exit_go |=> (status_w & ~ST_DOWN) == ST_NONE [*2])
    else $error("status not clear after exit");
  chk_rec_ring: assert property (
    bb_trigger |=> rec_data[$past(rec_wp_r)][23:0] == $past(snap_in) && rec_cnt_r <= REC_NUM && rec_wp_r <= REC_LAST)
    else $error("event record not stored in ring");
  chk_apb_ready: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb ready not a single pulse");
endmodule // fubl_core

// *** fubl_host_model.sv ***
// host model: writes commands and reads replies over the received byte stream
module fubl_host_model (
  input wire logic clk,
  output logic rx_start,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_stop,
  output logic tx_pop,
  input wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  import fubl_pkg::*;
  // address byte value is arbitrary, the front end has matched it already
  localparam logic [7:0] ADDR_WR = 8'hb0;
  logic [7:0] rd_q [$];
  initial {rx_start, rx_valid, rx_stop, tx_pop, rx_byte} = '0;
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? {c[6:0], 1'b0} ^ CRC8_POLY : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic pulse_start();
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
  endtask
  // bytes follow back to back; rest() releases the lines after the last one
  task automatic put(input logic [7:0] b);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
  endtask
  // released byte lines show the inverse so a stale byte never passes
  task automatic rest();
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
  // write framed by start and stop, pec last, corrupted on request
  task automatic send(input logic [7:0] body [$], input logic bad_pec);
    logic [7:0] c;
    c = crc8(8'h00, ADDR_WR);
    pulse_start();
    put(ADDR_WR);
    foreach (body[i]) begin
      c = crc8(c, body[i]);
      put(body[i]);
    end
    put(bad_pec ? ~c : c);
    rest();
    @(posedge clk);
    rx_stop <= 1'b1;
    @(posedge clk);
    rx_stop <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // command, repeated start, then pop n reply bytes
  task automatic query(input logic [7:0] cmd, input int n);
    rd_q = {};
    pulse_start();
    put(ADDR_WR);
    put(cmd);
    if (cmd == CMD_STATUS)
      put(8'h70);
    rest();
    pulse_start();
    repeat (n) begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rd_q.push_back(tx_byte);
      @(posedge clk);
      tx_pop <= 1'b1;
      @(posedge clk);
      tx_pop <= 1'b0;
    end
    rx_stop <= 1'b1;
    @(posedge clk);
    rx_stop <= 1'b0;
    @(posedge clk);
  endtask
endmodule // fubl_host_model

// *** test_firmware_upgrade_boot_loader.sv ***
// self-checking bench for the boot loader command handler
module test_firmware_upgrade_boot_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import fubl_pkg::*;
  typedef struct packed {logic [7:0] c, x, y, p0, p1, st; logic [15:0] sq;} fubl_row_t;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic erase_done = 1'b0, bb_trigger = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [23:0] snap_in = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rx_start, rx_valid, rx_stop, tx_pop;
  logic out_disable, sw_reboot, wdog_reboot, erase_req, prog_we;
  logic [7:0] rx_byte, tx_byte, prog_data, last_wd;
  logic [APP_AW-1:0] prog_addr, last_wa;
  logic [15:0] img;
  fubl_row_t rows [6];
  fubl_row_t r;
  int error_cnt = 0, check_count = 0, n_sw = 0, n_wd = 0, n_er = 0, n_we = 0;
  initial forever #2.5 clk = ~clk;
  fubl_core #(.TICK_CYC(4)) u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_stop(rx_stop), .tx_pop(tx_pop), .tx_byte(tx_byte), .out_disable(out_disable),
    .sw_reboot(sw_reboot), .wdog_reboot(wdog_reboot), .erase_req(erase_req),
    .erase_done(erase_done), .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
    .bb_trigger(bb_trigger), .snap_in(snap_in));
  fubl_host_model u_host (.clk(clk), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_stop(rx_stop), .tx_pop(tx_pop), .tx_byte(tx_byte));
  always @(posedge clk) begin
    n_sw <= n_sw + int'(sw_reboot === 1'b1);
    n_wd <= n_wd + int'(wdog_reboot === 1'b1);
    n_er <= n_er + int'(erase_req === 1'b1);
    n_we <= n_we + int'(prog_we === 1'b1);
    if (prog_we === 1'b1) begin
      last_wd <= prog_data;
      last_wa <= prog_addr;
    end
  end
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? {c[14:0], 1'b0} ^ CRC16_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // judged at the exit edge; a late but valid ready is no timeout
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic status_is(input logic [7:0] st);
    u_host.query(CMD_STATUS, 1);
    check("status", u_host.rd_q[0], st);
  endtask
  task automatic xfer_is(input logic [15:0] sq, input logic [7:0] st);
    u_host.query(CMD_XFER, 4);
    check("count", u_host.rd_q[0], XFER_COUNT);
    check("seq", {u_host.rd_q[2], u_host.rd_q[1]}, sq);
    check("xfer status", u_host.rd_q[3], st);
  endtask
  task automatic pulse_erase();
    repeat (4) @(posedge clk);
    erase_done <= 1'b1;
    @(posedge clk);
    erase_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic fresh_checks();
    @(posedge clk);
    check("off after reset", out_disable, 1'b0);
    apb(1'b0, A_CFG, '0);
    check("cfg", rd, CFG_RST);
    apb(1'b0, A_STAT, '0);
    check("stat", rd, 32'h0100_0000);
    apb(1'b0, 8'h20, '0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
  endtask
  initial begin
    img = crc16(crc16(16'h0000, 8'h12), 8'h34);
    // enter with junk target, erase, two packets ending in the image crc, done, exit
    rows[0] = {CMD_BOOT, 8'h3c, BL_ENTER, 16'h0000, ST_BOOT, 16'h0000};
    rows[1] = {CMD_BOOT, 8'h70, BL_ERASE, 16'h0000, 8'h81, 16'h0000};
    rows[2] = {CMD_XFER, 8'h00, 8'h00, 16'h1234, 8'h81, 16'h0001};
    rows[3] = {CMD_XFER, 8'h01, 8'h00, img, 8'h81, 16'h0002};
    rows[4] = {CMD_BOOT, 8'h70, BL_DONE, 16'h0000, ST_BOOT, 16'h0000};
    rows[5] = {CMD_BOOT, 8'hc3, BL_EXIT, 16'h0000, ST_NONE, 16'h0000};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    fresh_checks();
    // power factor stage target first, other applications marked valid
    apb(1'b1, A_CFG, 32'h0000_0170);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.c == CMD_XFER)
        u_host.send({r.c, r.x, r.y, r.p0, r.p1}, 1'b0);
      else
        u_host.send({r.c, r.x, r.y}, 1'b0);
      if (r.c == CMD_BOOT && r.y == BL_ERASE) begin
        status_is(ST_BOOT);
        pulse_erase();
      end
      // scaled settle time before the next query
      repeat (20) @(posedge clk);
      status_is(r.st);
      check("out off", out_disable, r.st[7]);
      if (r.c == CMD_XFER)
        xfer_is(r.sq, r.st);
    end
    check("enter pulses", n_sw, 1);
    check("erase pulses", n_er, 1);
    check("exit pulses", n_wd, 1);
    check("writes", n_we, 4);
    check("last byte", last_wd, img[7:0]);
    check("last addr", last_wa, 3);
    u_host.send({CMD_BOOT, 8'h00, BL_ENTER}, 1'b0);
    u_host.send({CMD_BOOT, 8'h73, BL_ERASE}, 1'b0);
    check("wrong target", n_er, 1);
    u_host.send({CMD_BOOT, 8'h70, BL_ERASE}, 1'b0);
    pulse_erase();
    u_host.send({CMD_XFER, 8'h00, 8'h00, 8'h55, 8'h66}, 1'b1);
    xfer_is(16'h0000, 8'h81);
    // next packet carries the number read back
    u_host.send({CMD_XFER, u_host.rd_q[1], u_host.rd_q[2], 8'h55, 8'h66}, 1'b0);
    xfer_is(16'h0001, 8'h81);
    u_host.send({CMD_XFER, 8'h05, 8'h00, 8'h55, 8'h66}, 1'b0);
    xfer_is(16'h0001, ST_BOOT | ST_SEQ_ERR | ST_ERASED);
    // error flagged, the host abandons and exit must be refused
    u_host.send({CMD_BOOT, 8'h00, BL_EXIT}, 1'b0);
    check("exit refused", n_wd, 1);
    check("still off", out_disable, 1'b1);
    status_is(8'h85);
    // a failed check must never validate the image
    u_host.send({CMD_BOOT, 8'h70, BL_DONE}, 1'b0);
    status_is(8'h87);
    apb(1'b0, A_STAT, '0);
    check("app not valid", rd[24], 1'b0);
    // six snapshots into a ring of five
    for (int i = 1; i <= 6; i++) begin
      snap_in <= 24'(i);
      bb_trigger <= 1'b1;
      @(posedge clk);
      bb_trigger <= 1'b0;
      repeat (6) @(posedge clk);
    end
    apb(1'b0, A_RCNT, '0);
    check("records", rd, 5);
    apb(1'b1, A_RSEL, 32'h0);
    apb(1'b0, A_RDATA, '0);
    check("oldest overwritten", rd, {8'h87, 24'h6});
    apb(1'b1, A_RSEL, 32'h1);
    apb(1'b0, A_RDATA, '0);
    check("second record", rd, {8'h87, 24'h2});
    apb(1'b1, A_RSEL, 32'h5);
    apb(1'b0, A_RSEL, '0);
    check("index kept", rd, 1);
    apb(1'b1, A_CFG, 32'h0000_0370);
    apb(1'b0, A_STAT, '0);
    check("downstream bit", rd[7:0], 8'hc7);
    // second reset in mid-run restores the shipped state
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    fresh_checks();
    wrap_up();
  end
endmodule // test_firmware_upgrade_boot_loader
